// ### hdl/can_rx_pkg.sv
// constants, types and register map of the receive mailbox match block
package can_rx_pkg;
	// mailbox geometry
	localparam int NUM_MB = 16;
	localparam int MB_W = 4;
	localparam int ID_W = 29;
	localparam int DATA_W = 64;
	localparam logic [MB_W-1:0] MB_TOP = 4'hF;
	localparam logic [MB_W-1:0] MB_BOTTOM = 4'h0;
	// register bus byte addresses
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] OFS_DATA_PEND = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_REMOTE_PEND = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_UNREAD = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_IRQ_REQ = 12'h00C;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h010;
	localparam logic [ADDR_W-1:0] OFS_MB_BASE = 12'h100;
	localparam logic [ADDR_W-1:0] OFS_MB_END = 12'h300;
	// per mailbox window: 0x20 bytes, fields at these low offsets
	localparam int MB_LSB = 5;
	localparam logic [MB_LSB-1:0] FLD_CFG = 5'h00;
	localparam logic [MB_LSB-1:0] FLD_ID = 5'h04;
	localparam logic [MB_LSB-1:0] FLD_MASK = 5'h08;
	localparam logic [MB_LSB-1:0] FLD_DLO = 5'h0C;
	localparam logic [MB_LSB-1:0] FLD_DHI = 5'h10;
	localparam logic [MB_LSB-1:0] FLD_TYPE = 5'h14;
	// mailbox config bits
	localparam int CFG_RX_BIT = 0;
	localparam int CFG_NMC_BIT = 1;
	localparam int CFG_W = 2;
	// interrupt request bits
	localparam int IRQ_DATA_BIT = 1;
	localparam int IRQ_REMOTE_BIT = 2;
	localparam int IRQ_W = 3;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// search sequencer states
	typedef enum logic [0:0] {ST_IDLE, ST_SEARCH} search_state_type;
	// decoded register field
	typedef enum logic [3:0] {F_NONE, F_DATA_PEND, F_REMOTE_PEND, F_UNREAD, F_IRQ, F_STATUS,
		F_CFG, F_ID, F_MASK, F_DLO, F_DHI, F_TYPE} field_type;
	typedef struct packed {
		field_type field;
		logic [MB_W-1:0] mb;
	} reg_sel_type;
	// received frame from the bus interface logic
	typedef struct packed {
		logic [ID_W-1:0] id;
		logic remote;
		logic [DATA_W-1:0] data;
	} rx_frame_type;
endpackage

// ### hdl/can_rx_mailbox_match.sv
// receive mailbox search, acceptance and storage with register access
// How it works
// - search mailboxes fifteen down to zero
// - receive box check, then masked identifier compare
// - first hit latched, search stops, idle
// - sixth end bit: store or drop per mode
// - storing also overwrites mailbox identifier
// - highest numbered match always wins
// - remote overwritten by data: all flags set
// - data overwritten by remote: both interrupts
// - overrun mode: first frame flags, later unread
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module can_rx_mailbox_match
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// register bus write address and data
	input wire logic [can_rx_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// register bus write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// register bus read
	input wire logic [can_rx_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// bus interface logic events
	input wire logic arb_end,
	input wire logic eof6,
	input wire can_rx_pkg::rx_frame_type rx_frame
);
	import can_rx_pkg::*;

	// address decode shared by read and write paths
	function automatic reg_sel_type decode(input logic [ADDR_W-1:0] a);
		reg_sel_type s;
		logic [ADDR_W-1:0] rel;
		// mailbox number counts from the window base, not from address zero
		rel = a - OFS_MB_BASE;
		s.mb = rel[MB_LSB+MB_W-1:MB_LSB];
		s.field = F_NONE;
		if (a == OFS_DATA_PEND)
			s.field = F_DATA_PEND;
		else if (a == OFS_REMOTE_PEND)
			s.field = F_REMOTE_PEND;
		else if (a == OFS_UNREAD)
			s.field = F_UNREAD;
		else if (a == OFS_IRQ_REQ)
			s.field = F_IRQ;
		else if (a == OFS_STATUS)
			s.field = F_STATUS;
		else if (a >= OFS_MB_BASE && a < OFS_MB_END)
		begin
			if (a[MB_LSB-1:0] == FLD_CFG)
				s.field = F_CFG;
			else if (a[MB_LSB-1:0] == FLD_ID)
				s.field = F_ID;
			else if (a[MB_LSB-1:0] == FLD_MASK)
				s.field = F_MASK;
			else if (a[MB_LSB-1:0] == FLD_DLO)
				s.field = F_DLO;
			else if (a[MB_LSB-1:0] == FLD_DHI)
				s.field = F_DHI;
			else if (a[MB_LSB-1:0] == FLD_TYPE)
				s.field = F_TYPE;
		end
		return s;
	endfunction

	// byte enables widened to a bit mask
	function automatic logic [31:0] lanes(input logic [3:0] strb);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int b = 0; b < 4; b++)
			m[b*8 +: 8] = {8{strb[b]}};
		return m;
	endfunction

	// bus handshake state
	logic awready_q, awready_d, wready_q, wready_d;
	logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
	logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	// mailbox storage
	logic [CFG_W-1:0] cfg_q [NUM_MB], cfg_d [NUM_MB];
	logic [ID_W-1:0] id_q [NUM_MB], id_d [NUM_MB];
	logic [ID_W-1:0] mask_q [NUM_MB], mask_d [NUM_MB];
	logic [DATA_W-1:0] msg_q [NUM_MB], msg_d [NUM_MB];
	logic [NUM_MB-1:0] is_remote_q, is_remote_d;
	// receive flags
	logic [NUM_MB-1:0] data_frame_pending_q, data_frame_pending_d;
	logic [NUM_MB-1:0] remote_frame_pending_q, remote_frame_pending_d;
	logic [NUM_MB-1:0] unread_message_status_q, unread_message_status_d;
	logic [IRQ_W-1:0] interrupt_request_register_q, interrupt_request_register_d;
	// search sequencer
	search_state_type state_q, state_d;
	logic [MB_W-1:0] idx_q, idx_d, hit_mb_q, hit_mb_d;
	logic hit_valid_q, hit_valid_d;
	logic [ID_W-1:0] rx_id_q, rx_id_d;
	// scratch
	reg_sel_type wsel, rsel;
	logic [31:0] wm, clr;
	logic old_unread;

	// next state of bus slave, registers and sequencer
	always_comb
	begin
		awready_d = awready_q;
		wready_d = wready_q;
		aw_hold_d = aw_hold_q;
		w_hold_d = w_hold_q;
		aw_addr_d = aw_addr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		arready_d = arready_q;
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		cfg_d = cfg_q;
		id_d = id_q;
		mask_d = mask_q;
		msg_d = msg_q;
		is_remote_d = is_remote_q;
		data_frame_pending_d = data_frame_pending_q;
		remote_frame_pending_d = remote_frame_pending_q;
		unread_message_status_d = unread_message_status_q;
		interrupt_request_register_d = interrupt_request_register_q;
		state_d = state_q;
		idx_d = idx_q;
		hit_mb_d = hit_mb_q;
		hit_valid_d = hit_valid_q;
		rx_id_d = rx_id_q;
		wsel = decode(aw_addr_q);
		rsel = decode(s_axi_araddr);
		wm = lanes(wstrb_q);
		clr = wdata_q & wm;
		old_unread = data_frame_pending_q[hit_mb_q] | remote_frame_pending_q[hit_mb_q];
		// address and data captured independently
		if (s_axi_awvalid && awready_q)
		begin
			aw_hold_d = 1'b1;
			aw_addr_d = s_axi_awaddr;
			awready_d = 1'b0;
		end
		if (s_axi_wvalid && wready_q)
		begin
			w_hold_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
			wready_d = 1'b0;
		end
		// write performed once both halves are held; flag clears go first
		if (aw_hold_q && w_hold_q && !bvalid_q)
		begin
			aw_hold_d = 1'b0;
			w_hold_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = (wsel.field == F_NONE || wsel.field == F_STATUS) ? RESP_SLVERR : RESP_OKAY;
			case (wsel.field)
				F_DATA_PEND: data_frame_pending_d = data_frame_pending_q & ~clr[NUM_MB-1:0];
				F_REMOTE_PEND: remote_frame_pending_d = remote_frame_pending_q & ~clr[NUM_MB-1:0];
				F_UNREAD: unread_message_status_d = unread_message_status_q & ~clr[NUM_MB-1:0];
				F_IRQ: interrupt_request_register_d = interrupt_request_register_q & ~clr[IRQ_W-1:0];
				F_CFG: cfg_d[wsel.mb] = (cfg_q[wsel.mb] & ~wm[CFG_W-1:0]) | clr[CFG_W-1:0];
				F_ID: id_d[wsel.mb] = (id_q[wsel.mb] & ~wm[ID_W-1:0]) | clr[ID_W-1:0];
				F_MASK: mask_d[wsel.mb] = (mask_q[wsel.mb] & ~wm[ID_W-1:0]) | clr[ID_W-1:0];
				default: ;
			endcase
		end
		// response retired, both address and data channels reopen
		if (bvalid_q && s_axi_bready)
		begin
			bvalid_d = 1'b0;
			awready_d = 1'b1;
			wready_d = 1'b1;
		end
		// read answered the cycle after the address is taken
		if (s_axi_arvalid && arready_q)
		begin
			arready_d = 1'b0;
			rvalid_d = 1'b1;
			rresp_d = RESP_OKAY;
			rdata_d = 32'h0000_0000;
			case (rsel.field)
				F_DATA_PEND: rdata_d[NUM_MB-1:0] = data_frame_pending_q;
				F_REMOTE_PEND: rdata_d[NUM_MB-1:0] = remote_frame_pending_q;
				F_UNREAD: rdata_d[NUM_MB-1:0] = unread_message_status_q;
				F_IRQ: rdata_d[IRQ_W-1:0] = interrupt_request_register_q;
				F_STATUS: rdata_d[MB_W+1:0] = {hit_valid_q, state_q == ST_SEARCH, hit_mb_q};
				F_CFG: rdata_d[CFG_W-1:0] = cfg_q[rsel.mb];
				F_ID: rdata_d[ID_W-1:0] = id_q[rsel.mb];
				F_MASK: rdata_d[ID_W-1:0] = mask_q[rsel.mb];
				F_DLO: rdata_d = msg_q[rsel.mb][31:0];
				F_DHI: rdata_d = msg_q[rsel.mb][DATA_W-1:32];
				F_TYPE: rdata_d[0] = is_remote_q[rsel.mb];
				default: rresp_d = RESP_SLVERR;
			endcase
		end
		if (rvalid_q && s_axi_rready)
		begin
			rvalid_d = 1'b0;
			arready_d = 1'b1;
		end
		// one mailbox checked per cycle
		case (state_q)
			ST_IDLE:
			begin
				if (arb_end)
				begin
					state_d = ST_SEARCH;
					idx_d = MB_TOP;
					hit_valid_d = 1'b0;
					rx_id_d = rx_frame.id;
				end
			end
			ST_SEARCH:
			begin
				// receive box first, then masked compare
				if (cfg_q[idx_q][CFG_RX_BIT] && ((id_q[idx_q] ^ rx_id_q) & ~mask_q[idx_q]) == '0)
				begin
					hit_valid_d = 1'b1;
					hit_mb_d = idx_q;
					state_d = ST_IDLE;
				end
				else if (idx_q == MB_BOTTOM)
					state_d = ST_IDLE;
				else
					idx_d = idx_q - 1'b1;
			end
			default: state_d = ST_IDLE;
		endcase
		// end of frame: store or drop; hardware sets win over clears above
		if (eof6)
		begin
			state_d = ST_IDLE;
			hit_valid_d = 1'b0;
			if (hit_valid_q && state_q == ST_IDLE)
			begin
				if (!cfg_q[hit_mb_q][CFG_NMC_BIT] && old_unread)
					unread_message_status_d[hit_mb_q] = 1'b1;
				else
				begin
					id_d[hit_mb_q] = rx_frame.id;
					msg_d[hit_mb_q] = rx_frame.data;
					is_remote_d[hit_mb_q] = rx_frame.remote;
					if (rx_frame.remote)
					begin
						remote_frame_pending_d[hit_mb_q] = 1'b1;
						interrupt_request_register_d[IRQ_REMOTE_BIT] = 1'b1;
					end
					else
					begin
						data_frame_pending_d[hit_mb_q] = 1'b1;
						interrupt_request_register_d[IRQ_DATA_BIT] = 1'b1;
					end
					// overwrite of an unread frame raises both interrupts
					if (old_unread)
					begin
						unread_message_status_d[hit_mb_q] = 1'b1;
						interrupt_request_register_d[IRQ_DATA_BIT] = 1'b1;
						interrupt_request_register_d[IRQ_REMOTE_BIT] = 1'b1;
					end
				end
			end
		end
	end

	// registers only; synchronous reset
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			aw_addr_q <= '0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= 32'h0000_0000;
			for (int i = 0; i < NUM_MB; i++)
			begin
				cfg_q[i] <= '0;
				id_q[i] <= '0;
				mask_q[i] <= '0;
				msg_q[i] <= '0;
			end
			is_remote_q <= '0;
			data_frame_pending_q <= '0;
			remote_frame_pending_q <= '0;
			unread_message_status_q <= '0;
			interrupt_request_register_q <= '0;
			state_q <= ST_IDLE;
			idx_q <= MB_TOP;
			hit_mb_q <= MB_BOTTOM;
			hit_valid_q <= 1'b0;
			rx_id_q <= '0;
		end
		else
		begin
			awready_q <= awready_d;
			wready_q <= wready_d;
			aw_hold_q <= aw_hold_d;
			w_hold_q <= w_hold_d;
			aw_addr_q <= aw_addr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
			cfg_q <= cfg_d;
			id_q <= id_d;
			mask_q <= mask_d;
			msg_q <= msg_d;
			is_remote_q <= is_remote_d;
			data_frame_pending_q <= data_frame_pending_d;
			remote_frame_pending_q <= remote_frame_pending_d;
			unread_message_status_q <= unread_message_status_d;
			interrupt_request_register_q <= interrupt_request_register_d;
			state_q <= state_d;
			idx_q <= idx_d;
			hit_mb_q <= hit_mb_d;
			hit_valid_q <= hit_valid_d;
			rx_id_q <= rx_id_d;
		end
	end

	// outputs straight from flops
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;
endmodule

// ### testbench/can_node_model.sv
// far-side node model driving received frame events
`timescale 1ns/1ps
module can_node_model
(
	// clock
	input wire logic clk,
	// frame events
	output logic arb_end,
	output logic eof6,
	output can_rx_pkg::rx_frame_type rx_frame
);
	import can_rx_pkg::*;
	// quiet lines at start
	initial
	begin
		arb_end = 1'b0;
		eof6 = 1'b0;
		rx_frame = '0;
	end
	// one frame: arbitration end, room for a full search, sixth end bit
	task automatic send(input logic [ID_W-1:0] id, input logic rm, input logic [DATA_W-1:0] d);
		@(posedge clk);
		rx_frame <= '{id: id, remote: rm, data: d};
		arb_end <= 1'b1;
		@(posedge clk);
		arb_end <= 1'b0;
		repeat (18) @(posedge clk);
		eof6 <= 1'b1;
		@(posedge clk);
		eof6 <= 1'b0;
		// frame over: lines no longer carry it
		rx_frame <= ~rx_frame;
		@(posedge clk);
	endtask
endmodule

// ### testbench/can_rx_mailbox_match_checker.sv
// register bus handshake checks for the mailbox block
`timescale 1ns/1ps
module can_rx_mailbox_match_checker
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// write channels
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// read channels
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// both write halves taken together
	sequence both_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// response handed over
	sequence b_done;
		s_axi_bvalid && s_axi_bready;
	endsequence
	a_aw_drop: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready) else $error("awready stayed up");
	a_w_drop: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready) else $error("wready stayed up");
	a_b_timing: assert property (both_taken |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer timing");
	a_w_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
	a_b_release: assert property (b_done |=> !s_axi_bvalid && s_axi_awready) else $error("write not released");
	a_r_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
	a_r_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
	a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready) else $error("read stuck");
endmodule
bind can_rx_mailbox_match can_rx_mailbox_match_checker chk_u (.clk(clk), .sys_rst(sys_rst),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready));

// ### testbench/can_rx_mailbox_match_bench.sv
// self-checking bench for the mailbox match block
`timescale 1ns/1ps
module can_rx_mailbox_match_bench;
	import can_rx_pkg::*;
	// frame case: id, remote, expected data pend, remote pend, irq
	typedef struct {logic [28:0] id; logic rm; logic [31:0] dp; logic [31:0] rp; logic [31:0] iq;} row_type;
	localparam logic [63:0] D1 = 64'h1122334455667788;
	localparam logic [63:0] D2 = 64'h99AABBCCDDEEFF00;
	row_type rows [4] = '{'{29'h100, 1'b0, 32'h8000, 32'h0, 32'h2}, '{29'h105, 1'b1, 32'h0, 32'h8000, 32'h4},
		'{29'h200, 1'b0, 32'h0, 32'h0, 32'h0}, '{29'h333, 1'b0, 32'h0, 32'h0, 32'h0}};
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	// bus master signals
	logic [ADDR_W-1:0] awaddr = '0;
	logic [ADDR_W-1:0] araddr = '0;
	logic [31:0] wdata = '0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	wire logic awready, wready, bvalid, arready, rvalid, arb_end, eof6;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire rx_frame_type rx_frame;
	// results and counters
	logic [31:0] rdat;
	logic [1:0] rres, bres;
	int errors = 0;
	int checked = 0;
	int cycles = 0;
	int i;
	always #25 clk = ~clk;
	can_node_model node_u (.clk(clk), .arb_end(arb_end), .eof6(eof6), .rx_frame(rx_frame));
	can_rx_mailbox_match dut_u (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .arb_end(arb_end), .eof6(eof6),
		.rx_frame(rx_frame));
	// compare and count
	task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one write, each channel released when taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		bres = bresp;
		bready <= 1'b0;
		@(posedge clk);
	endtask
	// one read
	task automatic rd(input logic [11:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		rdat = rdata;
		rres = rresp;
		rready <= 1'b0;
		@(posedge clk);
	endtask
	// mailbox field address
	function automatic logic [ADDR_W-1:0] mb(input logic [MB_W-1:0] n, input logic [MB_LSB-1:0] f);
		return OFS_MB_BASE + {3'h0, n, f};
	endfunction
	// set up one mailbox
	task automatic cfg(input logic [3:0] n, input logic [31:0] id, input logic [31:0] m, input logic [31:0] c);
		wr(mb(n, FLD_CFG), c);
		wr(mb(n, FLD_ID), id);
		wr(mb(n, FLD_MASK), m);
	endtask
	// check all flag words
	task automatic flags(input logic [31:0] dp, input logic [31:0] rp, input logic [31:0] um, input logic [31:0] iq);
		rd(OFS_DATA_PEND);
		cmp(rdat, dp);
		rd(OFS_REMOTE_PEND);
		cmp(rdat, rp);
		rd(OFS_UNREAD);
		cmp(rdat, um);
		rd(OFS_IRQ_REQ);
		cmp(rdat, iq);
	endtask
	// clear every sticky flag
	task automatic clr;
		wr(OFS_DATA_PEND, 32'hFFFF);
		wr(OFS_REMOTE_PEND, 32'hFFFF);
		wr(OFS_UNREAD, 32'hFFFF);
		wr(OFS_IRQ_REQ, 32'h6);
	endtask
	// closing report
	task automatic print_verdict;
		$display("checks %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// hang guard
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			errors++;
			print_verdict();
		end
	end
	// main sequence
	initial
	begin
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		flags(0, 0, 0, 0);
		rd(OFS_STATUS);
		cmp(rdat, 0);
		// two receive boxes share an id, a send box holds another
		cfg(15, 32'h100, 32'hF, 32'h3);
		cfg(3, 32'h100, 32'h0, 32'h1);
		cfg(5, 32'h200, 32'h0, 32'h2);
		for (i = 0; i < 4; i++)
		begin
			node_u.send(rows[i].id, rows[i].rm, D1);
			flags(rows[i].dp, rows[i].rp, 0, rows[i].iq);
			clr();
		end
		cmp({30'h0, bres}, {30'h0, RESP_OKAY});
		rd(mb(3, FLD_DLO));
		cmp(rdat, 0);
		rd(mb(15, FLD_ID));
		cmp(rdat, 32'h105);
		// remote then data into overwrite box
		node_u.send(29'h100, 1'b1, D2);
		node_u.send(29'h100, 1'b0, D1);
		flags(32'h8000, 32'h8000, 32'h8000, 32'h6);
		rd(mb(15, FLD_DHI));
		cmp(rdat, D1[63:32]);
		rd(mb(15, FLD_TYPE));
		cmp(rdat, 0);
		clr();
		// data then remote
		node_u.send(29'h100, 1'b0, D2);
		node_u.send(29'h100, 1'b1, D1);
		flags(32'h8000, 32'h8000, 32'h8000, 32'h6);
		rd(mb(15, FLD_TYPE));
		cmp(rdat, 1);
		clr();
		// overrun box keeps the first frame
		cfg(3, 32'h400, 32'h0, 32'h1);
		node_u.send(29'h400, 1'b0, D1);
		node_u.send(29'h400, 1'b1, D2);
		flags(32'h8, 32'h0, 32'h8, 32'h2);
		rd(mb(3, FLD_DLO));
		cmp(rdat, D1[31:0]);
		// mid-run reset clears every flag and mailbox field
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		flags(0, 0, 0, 0);
		rd(mb(15, FLD_ID));
		cmp(rdat, 0);
		// unmapped read and read-only write refused
		rd(12'h020);
		cmp(rdat, 0);
		cmp({30'h0, rres}, {30'h0, RESP_SLVERR});
		wr(OFS_STATUS, 32'hFFFF);
		cmp({30'h0, bres}, {30'h0, RESP_SLVERR});
		print_verdict();
	end
endmodule
